// ===== core/dac_pins_pkg.sv
package dac_pins_pkg;

	// =====================================================================
	// Link and sample widths
	// =====================================================================
	localparam int SAMPLE_W = 16;
	localparam int WORD_W   = 32;
	localparam int FIFO_DEPTH = 16;

	// =====================================================================
	// Serial configuration frame: rw bit, 7-bit address, 8-bit data
	// =====================================================================
	localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
	localparam logic [3:0] INSTR_LAST_BIT = 4'h7;
	localparam int         FRAME_RW_POS   = 15;
	localparam int         INSTR_RW_POS   = 7;

	// Device configuration addresses
	localparam logic [6:0] REG_MODE     = 7'h01;
	localparam logic [6:0] REG_SYNC_SEL = 7'h02;
	localparam logic [6:0] REG_STATUS   = 7'h03;
	localparam logic [6:0] REG_IFACE    = 7'h04;

	// Field positions in the mode register
	localparam int MODE_INTERLEAVE = 0;
	localparam int MODE_MARKER     = 1;
	localparam int MODE_REVERSE    = 2;
	localparam int MODE_PLL        = 3;
	localparam int MODE_LOCK_CLK   = 4;

	// Field positions in the sync select register
	localparam int SYNC_NCO     = 0;
	localparam int SYNC_MIXER   = 1;
	localparam int SYNC_DIVIDER = 2;
	localparam int SYNC_FIFO    = 3;

	// Interface configuration: four-pin mode bit
	localparam int IFACE_FOUR_PIN = 7;

	// Reset values
	localparam logic [7:0] MODE_RESET     = 8'h00;
	localparam logic [7:0] SYNC_SEL_RESET = 8'h0F;
	localparam logic [7:0] IFACE_RESET    = 8'h00;

	// =====================================================================
	// Host controller AHB-Lite register offsets and fields
	// =====================================================================
	localparam logic [7:0] HOST_CTRL   = 8'h00;
	localparam logic [7:0] HOST_SYNC   = 8'h04;
	localparam logic [7:0] HOST_SER    = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0C;

	localparam int CTRL_GATE_EN    = 0;
	localparam int CTRL_INTERLEAVE = 1;
	localparam int CTRL_MARKER     = 2;
	localparam int CTRL_SLEEP      = 3;
	localparam int CTRL_CHIP_RST   = 4;
	localparam int CTRL_FOUR_PIN   = 5;
	localparam int CTRL_W          = 6;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

	// Serial clock: last count of the half period in system clocks
	localparam logic [2:0] SCLK_HALF_LAST = 3'h3;

endpackage : dac_pins_pkg

// ===== core/dac_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dac_link_if;
	import dac_pins_pkg::*;

	logic                transmit_gate;
	logic [SAMPLE_W-1:0] channel_a_samples;
	logic [SAMPLE_W-1:0] channel_b_samples;
	logic                b_marker;
	logic                phase_sync_strobe;
	logic                lock_indicator_out;
	logic                chip_reset_low;
	logic                sleep_req;
	logic                sclk;
	logic                serial_select_low;
	logic                sdio_host_o;
	logic                sdio_host_oe;
	logic                sdio_dev_o;
	logic                sdio_dev_oe;
	logic                serial_out_line_o;
	logic                serial_out_line_oe;
	logic                sdio_level;
	logic                serial_out_level;

	// Pulled-up wires when nobody drives
	assign sdio_level       = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);
	assign serial_out_level = serial_out_line_oe ? serial_out_line_o : 1'b1;

	modport device (
		input  transmit_gate, channel_a_samples, channel_b_samples, b_marker,
		input  phase_sync_strobe, chip_reset_low, sleep_req, sclk, serial_select_low, sdio_level,
		output lock_indicator_out, sdio_dev_o, sdio_dev_oe, serial_out_line_o, serial_out_line_oe
	);

	modport host (
		output transmit_gate, channel_a_samples, channel_b_samples, b_marker,
		output phase_sync_strobe, chip_reset_low, sleep_req, sclk, serial_select_low,
		output sdio_host_o, sdio_host_oe,
		input  lock_indicator_out, sdio_level, serial_out_level
	);

endinterface : dac_link_if

`default_nettype wire

// ===== core/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Drain side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data   = mem[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Flags registered from the next count so ready and valid are flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready   <= 1'b0;
			out_valid  <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_next;
			in_ready   <= count_next != (AW+1)'(DEPTH);
			out_valid  <= count_next != '0;
		end
	end

endmodule : sample_fifo

`default_nettype wire

// ===== core/dac_device_end.sv
// How it works
// - Data passes only while gate high
// - Gate low forces zero, ignores ports
// - Toggle pairing: first after rise is A
// - Marker mode: marked samples go to B
// - Source marks every B sample
// - Sync strobe initialises selected blocks
// - PLL mode: lock bit or internal clock
// - External mode: input rate clock out
// - Low reset input holds chip, but lock output and sleep still run
// - Data line bidirectional only in three-pin
// - Reset default is three-pin mode
// - Serial out drives only in four-pin
// - Sleep is asynchronous active-high power-down
// - True full at ones, comp at zeros
// - Select low frames transfers, input only
// - Sample port bit order reversible
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module dac_device_end (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// Link to the sample source
	dac_link_if.device                         link,
	// Loop status from the clock multiplier
	input  wire logic                          pll_locked,
	// Converter codes
	output logic [dac_pins_pkg::SAMPLE_W-1:0]  chan_a_true_output,
	output logic [dac_pins_pkg::SAMPLE_W-1:0]  chan_a_comp_output,
	output logic [dac_pins_pkg::SAMPLE_W-1:0]  chan_b_true_output,
	output logic [dac_pins_pkg::SAMPLE_W-1:0]  chan_b_comp_output,
	output logic                               sample_valid,
	// Initialisation pulses
	output logic                               sync_nco,
	output logic                               sync_mixer,
	output logic                               sync_divider,
	output logic                               sync_fifo,
	// Power state
	output logic                               power_down
);
	import dac_pins_pkg::*;

	typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_DONE} ser_state_type;

	// =====================================================================
	// Chip reset and configuration
	// =====================================================================
	logic [7:0]          mode_reg;
	logic [7:0]          sync_sel_reg;
	logic [7:0]          iface_reg;
	logic                sclk_prev_reg;
	logic                strobe_prev_reg;
	logic [1:0]          div_reg;
	logic                phase_reg;
	ser_state_type       ser_state_reg;
	logic [3:0]          bit_cnt_reg;
	logic [14:0]         shift_in_reg;
	logic [7:0]          out_shift_reg;
	logic                reading_reg;

	wire hold = ~link.chip_reset_low;

	wire interleave = mode_reg[MODE_INTERLEAVE];
	wire marker_en  = mode_reg[MODE_MARKER];
	wire four_pin   = iface_reg[IFACE_FOUR_PIN];

	// =====================================================================
	// Serial port decode
	// =====================================================================
	// select frames transfers
	wire        selected   = ~link.serial_select_low;
	wire        sclk_rise  = link.sclk & ~sclk_prev_reg;
	wire        sclk_fall  = ~link.sclk & sclk_prev_reg;
	wire        bit_in     = link.sdio_level;
	wire        shift_ok   = selected & sclk_rise & (ser_state_reg != SER_DONE);
	wire [15:0] frame_word = {shift_in_reg, bit_in};
	wire [7:0]  instr_word = {shift_in_reg[6:0], bit_in};
	wire        last_bit   = bit_cnt_reg == FRAME_LAST_BIT;
	wire        instr_done = bit_cnt_reg == INSTR_LAST_BIT;
	wire        ser_write  = shift_ok & last_bit & ~frame_word[FRAME_RW_POS];
	wire        ser_read   = shift_ok & instr_done & instr_word[INSTR_RW_POS];
	wire [6:0]  wr_addr    = frame_word[14:8];
	wire [7:0]  wr_data    = frame_word[7:0];
	wire [6:0]  rd_addr    = instr_word[6:0];
	wire [7:0]  status_val = {6'h00, power_down, pll_locked};
	wire [7:0]  rd_data    = (rd_addr == REG_MODE)     ? mode_reg :
	                         (rd_addr == REG_SYNC_SEL) ? sync_sel_reg :
	                         (rd_addr == REG_STATUS)   ? status_val :
	                         (rd_addr == REG_IFACE)    ? iface_reg : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg     <= MODE_RESET;
			sync_sel_reg <= SYNC_SEL_RESET;
			iface_reg    <= IFACE_RESET;
		end else if (hold) begin
			mode_reg     <= MODE_RESET;
			sync_sel_reg <= SYNC_SEL_RESET;
			iface_reg    <= IFACE_RESET;
		end else if (ser_write) begin
			if (wr_addr == REG_MODE) begin
				mode_reg <= wr_data;
			end
			if (wr_addr == REG_SYNC_SEL) begin
				sync_sel_reg <= wr_data;
			end
			if (wr_addr == REG_IFACE) begin
				iface_reg <= wr_data;
			end
		end
	end

	// =====================================================================
	// Serial port shifter
	// =====================================================================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_prev_reg <= 1'b0;
			ser_state_reg <= SER_IDLE;
			bit_cnt_reg   <= 4'h0;
			shift_in_reg  <= 15'h0000;
			out_shift_reg <= 8'h00;
			reading_reg   <= 1'b0;
		end else begin
			sclk_prev_reg <= link.sclk;
			if (hold || !selected) begin
				ser_state_reg <= SER_IDLE;
				bit_cnt_reg   <= 4'h0;
				reading_reg   <= 1'b0;
			end else begin
				unique case (ser_state_reg)
					SER_IDLE: begin
						ser_state_reg <= SER_SHIFT;
					end
					SER_SHIFT: begin
						if (shift_ok && last_bit) begin
							ser_state_reg <= SER_DONE;
						end
					end
					SER_DONE: begin
						ser_state_reg <= SER_DONE;
					end
				endcase
				if (shift_ok) begin
					shift_in_reg <= frame_word[14:0];
					bit_cnt_reg  <= bit_cnt_reg + 4'h1;
				end
				if (ser_read) begin
					out_shift_reg <= rd_data;
					reading_reg   <= 1'b1;
				end else if (shift_ok && last_bit) begin
					reading_reg <= 1'b0;
				end else if (sclk_fall && reading_reg) begin
					out_shift_reg <= {out_shift_reg[6:0], 1'b0};
				end
			end
		end
	end

	// Read bits change on the falling edge so the master samples on the rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link.sdio_dev_o         <= 1'b0;
			link.sdio_dev_oe        <= 1'b0;
			link.serial_out_line_o  <= 1'b0;
			link.serial_out_line_oe <= 1'b0;
		end else if (hold || !selected || !reading_reg || (shift_ok && last_bit)) begin
			link.sdio_dev_oe        <= 1'b0;
			link.serial_out_line_oe <= 1'b0;
		end else if (sclk_fall) begin
			link.sdio_dev_o         <= out_shift_reg[7];
			link.sdio_dev_oe        <= ~four_pin;
			link.serial_out_line_o  <= out_shift_reg[7];
			link.serial_out_line_oe <= four_pin;
		end
	end

	// =====================================================================
	// Sample path
	// =====================================================================
	// bit order reversal
	wire [SAMPLE_W-1:0] a_rev  = {<<{link.channel_a_samples}};
	wire [SAMPLE_W-1:0] b_rev  = {<<{link.channel_b_samples}};
	wire [SAMPLE_W-1:0] a_in   = mode_reg[MODE_REVERSE] ? a_rev : link.channel_a_samples;
	wire [SAMPLE_W-1:0] b_in   = mode_reg[MODE_REVERSE] ? b_rev : link.channel_b_samples;
	// gate qualifies data, gate low in reset
	wire gate_ok = link.transmit_gate & ~hold & ~power_down;
	// marker picks B, else alternate from A
	wire is_b    = marker_en ? link.b_marker : phase_reg;
	wire take_a  = gate_ok & (~interleave | ~is_b);
	wire take_b  = gate_ok & (~interleave | is_b);
	wire [SAMPLE_W-1:0] a_next = !gate_ok ? '0 : take_a ? a_in : chan_a_true_output;
	wire [SAMPLE_W-1:0] b_next = !gate_ok ? '0 : !take_b ? chan_b_true_output :
	                             interleave ? a_in : b_in;
	wire valid_next = take_b;
	// pairing restarts at each gate rise
	wire phase_next = gate_ok & interleave & ~is_b;

	// complement reaches full scale at zero code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chan_a_true_output <= '0;
			chan_a_comp_output <= '1;
			chan_b_true_output <= '0;
			chan_b_comp_output <= '1;
			sample_valid       <= 1'b0;
			phase_reg          <= 1'b0;
		end else begin
			chan_a_true_output <= a_next;
			chan_a_comp_output <= ~a_next;
			chan_b_true_output <= b_next;
			chan_b_comp_output <= ~b_next;
			sample_valid       <= valid_next;
			phase_reg          <= phase_next;
		end
	end

	// =====================================================================
	// Sync strobe and lock indicator
	// =====================================================================
	// strobe rise gated by chip reset, pulses by selects
	wire strobe_rise = link.phase_sync_strobe & ~strobe_prev_reg & ~hold;
	// PLL: status or divided clock, external: input rate
	wire lock_next   = mode_reg[MODE_PLL] ? (mode_reg[MODE_LOCK_CLK] ? div_reg[1] : pll_locked) : div_reg[0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobe_prev_reg         <= 1'b0;
			sync_nco                <= 1'b0;
			sync_mixer              <= 1'b0;
			sync_divider            <= 1'b0;
			sync_fifo               <= 1'b0;
			div_reg                 <= 2'h0;
			link.lock_indicator_out <= 1'b0;
		end else begin
			strobe_prev_reg         <= link.phase_sync_strobe;
			sync_nco                <= strobe_rise & sync_sel_reg[SYNC_NCO];
			sync_mixer              <= strobe_rise & sync_sel_reg[SYNC_MIXER];
			sync_divider            <= strobe_rise & sync_sel_reg[SYNC_DIVIDER];
			sync_fifo               <= strobe_rise & sync_sel_reg[SYNC_FIFO];
			div_reg                 <= div_reg + 2'h1;
			link.lock_indicator_out <= lock_next;
		end
	end

	// =====================================================================
	// Power-down
	// =====================================================================
	// asynchronous set, no clock needed
	always_ff @(posedge clk or posedge rst or posedge link.sleep_req) begin
		if (rst) begin
			power_down <= 1'b0;
		end else if (link.sleep_req) begin
			power_down <= 1'b1;
		end else begin
			power_down <= 1'b0;
		end
	end

endmodule : dac_device_end

`default_nettype wire

// ===== core/dac_host_end.sv
`timescale 1ns/1ps
`default_nettype none

module dac_host_end (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// AHB-Lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	// Sample stream, A in low half, B in high half
	input  wire logic [dac_pins_pkg::WORD_W-1:0] src_data,
	input  wire logic                        src_valid,
	output logic                             src_ready,
	// Link to the converter
	dac_link_if.host                         link
);
	import dac_pins_pkg::*;

	// =====================================================================
	// Bus slave, zero wait states
	// =====================================================================
	logic [CTRL_W-1:0] ctrl_reg;
	logic              wr_pend_reg;
	logic [7:0]        addr_q_reg;
	logic              lock_q_reg;
	logic              ser_busy_reg;
	logic [7:0]        rx_reg;
	logic [WORD_W-1:0] fifo_data;
	logic              fifo_valid;
	logic              tx_phase_reg;

	wire        addr_ph  = hsel & hready & htrans[1];
	wire        ctrl_wr  = wr_pend_reg & (addr_q_reg == HOST_CTRL);
	wire        sync_wr  = wr_pend_reg & (addr_q_reg == HOST_SYNC);
	wire        ser_wr   = wr_pend_reg & (addr_q_reg == HOST_SER);
	wire [31:0] status_v = {16'h0000, rx_reg, 4'h0, ~src_ready, ~fifo_valid, lock_q_reg, ser_busy_reg};
	wire [31:0] rd_mux   = (haddr[7:0] == HOST_CTRL)   ? {26'h000_0000, ctrl_reg} :
	                       (haddr[7:0] == HOST_STATUS) ? status_v : 32'h0000_0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			addr_q_reg  <= 8'h00;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			ctrl_reg    <= CTRL_RESET;
			lock_q_reg  <= 1'b0;
		end else begin
			wr_pend_reg <= addr_ph & hwrite;
			addr_q_reg  <= haddr[7:0];
			hrdata      <= (addr_ph & ~hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			lock_q_reg  <= link.lock_indicator_out;
			if (ctrl_wr) begin
				ctrl_reg <= hwdata[CTRL_W-1:0];
			end
		end
	end

	// =====================================================================
	// Sample buffer and transmit
	// =====================================================================
	wire interleave = ctrl_reg[CTRL_INTERLEAVE];
	// gate high only with data to send
	wire fire       = fifo_valid & ctrl_reg[CTRL_GATE_EN] & ~ctrl_reg[CTRL_CHIP_RST];
	wire pop        = fire & (~interleave | tx_phase_reg);

	sample_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (src_data),
		.in_valid  (src_valid),
		.in_ready  (src_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (pop)
	);

	wire [SAMPLE_W-1:0] a_next = !fire ? '0 : (interleave & tx_phase_reg) ? fifo_data[31:16] : fifo_data[15:0];
	wire [SAMPLE_W-1:0] b_next = (fire & ~interleave) ? fifo_data[31:16] : '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_phase_reg           <= 1'b0;
			link.transmit_gate     <= 1'b0;
			link.channel_a_samples <= '0;
			link.channel_b_samples <= '0;
			link.b_marker          <= 1'b0;
			link.phase_sync_strobe <= 1'b0;
			link.sleep_req         <= 1'b0;
			link.chip_reset_low    <= 1'b1;
		end else begin
			tx_phase_reg           <= fire & interleave & ~tx_phase_reg;
			link.transmit_gate     <= fire;
			link.channel_a_samples <= a_next;
			link.channel_b_samples <= b_next;
			// mark B samples, on every one
			link.b_marker          <= fire & interleave & tx_phase_reg & ctrl_reg[CTRL_MARKER];
			link.phase_sync_strobe <= sync_wr;
			link.sleep_req         <= ctrl_reg[CTRL_SLEEP];
			link.chip_reset_low    <= ~ctrl_reg[CTRL_CHIP_RST];
		end
	end

	// =====================================================================
	// Serial configuration master
	// =====================================================================
	logic [2:0]  div_reg;
	logic [3:0]  cnt_reg;
	logic [15:0] tx_reg;
	logic        is_read_reg;

	wire start   = ser_wr & ~ser_busy_reg;
	wire rx_pin  = ctrl_reg[CTRL_FOUR_PIN] ? link.serial_out_level : link.sdio_level;
	wire in_data = cnt_reg >= 4'h8;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ser_busy_reg           <= 1'b0;
			div_reg                <= 3'h0;
			cnt_reg                <= 4'h0;
			tx_reg                 <= 16'h0000;
			rx_reg                 <= 8'h00;
			is_read_reg            <= 1'b0;
			link.sclk              <= 1'b0;
			link.serial_select_low <= 1'b1;
			link.sdio_host_o       <= 1'b0;
			link.sdio_host_oe      <= 1'b0;
		end else if (start) begin
			ser_busy_reg           <= 1'b1;
			div_reg                <= 3'h0;
			cnt_reg                <= 4'h0;
			tx_reg                 <= hwdata[15:0];
			is_read_reg            <= hwdata[FRAME_RW_POS];
			link.sclk              <= 1'b0;
			link.serial_select_low <= 1'b0;
			link.sdio_host_o       <= hwdata[FRAME_RW_POS];
			link.sdio_host_oe      <= 1'b1;
		end else if (ser_busy_reg) begin
			div_reg <= (div_reg == SCLK_HALF_LAST) ? 3'h0 : div_reg + 3'h1;
			if (div_reg == SCLK_HALF_LAST && !link.sclk) begin
				link.sclk <= 1'b1;
				if (is_read_reg && in_data) begin
					rx_reg <= {rx_reg[6:0], rx_pin};
				end
			end else if (div_reg == SCLK_HALF_LAST) begin
				link.sclk <= 1'b0;
				if (cnt_reg == FRAME_LAST_BIT) begin
					ser_busy_reg           <= 1'b0;
					link.serial_select_low <= 1'b1;
					link.sdio_host_oe      <= 1'b0;
				end else begin
					// Released before the device drives the read byte
					cnt_reg           <= cnt_reg + 4'h1;
					tx_reg            <= {tx_reg[14:0], 1'b0};
					link.sdio_host_o  <= tx_reg[14];
					link.sdio_host_oe <= ~(is_read_reg & (cnt_reg >= INSTR_LAST_BIT));
				end
			end
		end
	end

endmodule : dac_host_end

`default_nettype wire

// ===== verification/dac_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Link checks
module dac_link_asserts
	import dac_pins_pkg::*;
(
	// Clock and reset
	input wire logic                clk,
	input wire logic                rst,
	// Link signals
	input wire logic                transmit_gate,
	input wire logic [SAMPLE_W-1:0] channel_a_samples,
	input wire logic [SAMPLE_W-1:0] channel_b_samples,
	input wire logic                b_marker,
	input wire logic                phase_sync_strobe,
	input wire logic                chip_reset_low,
	input wire logic                serial_select_low,
	input wire logic                sdio_dev_oe,
	input wire logic                serial_out_line_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	gate_zero_a: assert property (!transmit_gate |-> !channel_a_samples && !channel_b_samples)
		else $error("samples while gate low");
	marker_gate_a: assert property (b_marker |-> transmit_gate)
		else $error("marker without gate");
	first_a_a: assert property ($rose(transmit_gate) |-> !b_marker)
		else $error("first sample marked");
	sdo_frame_a: assert property (serial_out_line_oe |-> !serial_select_low)
		else $error("serial out outside frame");
	sdio_frame_a: assert property (sdio_dev_oe |-> !serial_select_low)
		else $error("data line outside frame");
	one_driver_a: assert property (!(sdio_dev_oe && serial_out_line_oe))
		else $error("both read lines driven");
	chip_rst_a: assert property (!chip_reset_low |=> !sdio_dev_oe && !serial_out_line_oe)
		else $error("driving in chip reset");
	strobe_pulse_a: assert property ($rose(phase_sync_strobe) |=> !phase_sync_strobe)
		else $error("strobe too long");
endmodule : dac_link_asserts
`default_nettype wire

// ===== verification/dual_dac_input_control_pins_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module dual_dac_input_control_pins_tb_top;
	import dac_pins_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0, src_valid = 1'b0, pll_locked = 1'b0;
	logic        rq, sq, hreadyout, src_ready, sample_valid, s_nco, s_fifo, power_down;
	logic [31:0] haddr = '0, hwdata = '0, src_data = '0, hrdata, hq, rd;
	logic [1:0]  htrans = '0;
	logic [15:0] a_t, a_c, b_t, b_c, la, lb, lc, ld;
	int          n_fail = 0, checked = 0, n;
	always #25 clk = ~clk;
	// Sample at the edge so reads never race the design
	always @(posedge clk) begin
		hq <= hrdata;
		rq <= hreadyout;
		sq <= src_ready;
	end
	dac_link_if i_dac_link_if ();
	dac_device_end i_dac_device_end (.clk(clk), .rst(rst), .link(i_dac_link_if.device), .pll_locked(pll_locked),
		.chan_a_true_output(a_t), .chan_a_comp_output(a_c), .chan_b_true_output(b_t), .chan_b_comp_output(b_c),
		.sample_valid(sample_valid), .sync_nco(s_nco), .sync_mixer(), .sync_divider(), .sync_fifo(s_fifo),
		.power_down(power_down));
	dac_host_end i_dac_host_end (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
		.src_data(src_data), .src_valid(src_valid), .src_ready(src_ready), .link(i_dac_link_if.host));
	dac_link_asserts i_dac_link_asserts (.clk(clk), .rst(rst), .transmit_gate(i_dac_link_if.transmit_gate),
		.channel_a_samples(i_dac_link_if.channel_a_samples), .channel_b_samples(i_dac_link_if.channel_b_samples),
		.b_marker(i_dac_link_if.b_marker), .phase_sync_strobe(i_dac_link_if.phase_sync_strobe),
		.chip_reset_low(i_dac_link_if.chip_reset_low), .serial_select_low(i_dac_link_if.serial_select_low),
		.sdio_dev_oe(i_dac_link_if.sdio_dev_oe), .serial_out_line_oe(i_dac_link_if.serial_out_line_oe));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do tick; while (rq !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do tick; while (rq !== 1'b1);
		rd = hq;
	endtask : ahb
	task automatic push(input logic [31:0] d);
		src_valid <= 1'b1;
		src_data <= d;
		do tick; while (sq !== 1'b1);
	endtask : push
	task automatic fill_drain;
		for (int i = 0; i < 16; i++) push({~i[15:0], i[15:0]});
		src_valid <= 1'b0;
		chk("src_ready", 0, src_ready);
		ahb(1'b1, HOST_CTRL, 32'h0000_0001);
		n = 0;
		for (int k = 0; k < 60; k++) begin
			tick;
			if (sample_valid === 1'b1) begin
				n++;
				la = a_t;
				lb = b_t;
				lc = a_c;
				ld = b_c;
			end
		end
		chk("pairs", 16, n);
		chk("a", 16'h000F, la);
		chk("b", 16'hFFF0, lb);
		chk("a comp", 16'hFFF0, lc);
		chk("b comp", 16'h000F, ld);
	endtask : fill_drain
	task automatic interleave;
		for (int m = 0; m < 2; m++) begin
			ser({8'h01, 5'h00, m[0], m[0], 1'b1}, 8'h00);
			ahb(1'b1, HOST_CTRL, {29'h0000_0000, m[0], 2'h3});
			push(32'h5555_AAAA);
			src_valid <= 1'b0;
			for (int k = 0; k < 20 && sample_valid !== 1'b1; k++) tick;
			chk("a", {8{~m[0], m[0]}}, a_t);
			chk("b", {8{m[0], ~m[0]}}, b_t);
		end
	endtask : interleave
	task automatic ser(input logic [15:0] f, input logic [7:0] e);
		int k;
		ahb(1'b1, HOST_SER, {16'h0000, f});
		k = 0;
		do begin
			ahb(1'b0, HOST_STATUS, '0);
			k++;
		end while (rd[0] !== 1'b0 && k < 100);
		chk("busy", 0, rd[0]);
		if (f[15]) chk("read byte", e, rd[15:8]);
	endtask : ser
	task automatic ctl;
		ahb(1'b1, HOST_SYNC, '0);
		n = 0;
		for (int k = 0; k < 10; k++) begin
			tick;
			if (s_fifo === 1'b1 && s_nco === 1'b1) n = 1;
		end
		chk("sync", 1, n);
		ahb(1'b1, HOST_CTRL, 32'h0000_0008);
		tick;
		chk("sleep", 1, power_down);
		ahb(1'b1, HOST_CTRL, '0);
		repeat (2) tick;
		chk("wake", 0, power_down);
		pll_locked <= 1'b1;
		ser(16'h0108, 8'h00);
		ahb(1'b0, HOST_STATUS, '0);
		chk("lock", 1, rd[1]);
		ahb(1'b0, 8'h40, '0);
		chk("unmapped", 0, rd);
		ser(16'h8400, 8'h00);
		ser(16'h0480, 8'h00);
		ahb(1'b1, HOST_CTRL, 32'h0000_0020);
		ser(16'h8400, 8'h80);
		ahb(1'b1, HOST_CTRL, 32'h0000_0010);
		ahb(1'b1, HOST_CTRL, '0);
		ser(16'h8400, 8'h00);
	endtask : ctl
	task automatic give_verdict;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		#2000000;
		n_fail++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		tick;
		fill_drain;
		interleave;
		ctl;
		give_verdict;
	end
endmodule : dual_dac_input_control_pins_tb_top
`default_nettype wire
